// ===== design/cpcr_coef_pair.sv
`timescale 1ns/1ps
module cpcr_coef_pair
	import cpcr_pkg::*;
#(
	parameter logic [7:0] RST_HIGH = 8'h00,
	parameter logic [7:0] RST_LOW  = 8'h00
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               wr_high,
	input  wire logic               wr_low,
	input  wire logic [7:0]         wdata,
	output logic signed [15:0]      coef
);
	cpcr_coef_state_t state_reg;
	cpcr_coef_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (wr_high) begin
			state_next.coef[15:8] = wdata;
		end
		if (wr_low) begin
			state_next.coef[7:0] = wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.coef <= {RST_HIGH, RST_LOW};
		end else begin
			state_reg <= state_next;
		end
	end

	// high byte is the sign-carrying half of a two's-complement word
	assign coef = $signed(state_reg.coef);
endmodule : cpcr_coef_pair

// ===== design/cpcr_pkg.sv
package cpcr_pkg;
	localparam logic [6:0] CPCR_IDX_PAGE_SEL   = 7'h00;
	localparam logic [6:0] CPCR_IDX_COEF0_HIGH = 7'h01;
	localparam logic [6:0] CPCR_IDX_COEF0_LOW  = 7'h02;
	localparam logic [6:0] CPCR_IDX_COEF1_HIGH = 7'h03;
	localparam logic [6:0] CPCR_IDX_COEF1_LOW  = 7'h04;
	localparam logic [6:0] CPCR_IDX_BYPASS     = 7'h6C;
	localparam logic [6:0] CPCR_IDX_DAC_CUR    = 7'h6D;
	localparam logic [6:0] CPCR_IDX_RSVD_FIRST = 7'h6E;
	localparam logic [7:0] CPCR_RST_PAGE_SEL   = 8'h00;
	localparam logic [7:0] CPCR_RST_COEF0_HIGH = 8'h6B;
	localparam logic [7:0] CPCR_RST_COEF0_LOW  = 8'hE3;
	localparam logic [7:0] CPCR_RST_COEF1_HIGH = 8'h96;
	localparam logic [7:0] CPCR_RST_COEF1_LOW  = 8'h66;
	localparam logic [7:0] CPCR_RST_BYPASS     = 8'h00;
	localparam logic [1:0] CPCR_RST_DAC_CUR    = 2'h0;
	localparam int         CPCR_DAC_CUR_LSB    = 6;
	localparam logic [1:0] CPCR_DAC_CUR_DEFAULT = 2'h0;
	localparam logic [1:0] CPCR_DAC_CUR_PLUS50  = 2'h1;
	localparam logic [1:0] CPCR_DAC_CUR_RSVD    = 2'h2;
	localparam logic [1:0] CPCR_DAC_CUR_PLUS100 = 2'h3;
	typedef struct packed {
		logic [15:0] coef;
	} cpcr_coef_state_t;
	typedef struct packed {
		logic        page;
		logic [7:0]  bypass;
		logic [1:0]  dac_cur;
		logic [7:0]  rdata;
		logic        rvalid;
	} cpcr_state_t;
endpackage : cpcr_pkg

// ===== design/cpcr_regs.sv
`timescale 1ns/1ps
module cpcr_regs
	import cpcr_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rst_b,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [6:0]         reg_idx,
	input  wire logic [7:0]         reg_wdata,
	output logic [7:0]              reg_rdata,
	output logic                    reg_rvalid,
	output logic                    active_page,
	output logic                    right_in_b_neg,
	output logic                    right_in_b_pos,
	output logic                    right_in_a_neg,
	output logic                    right_in_a_pos,
	output logic                    left_in_b_neg,
	output logic                    left_in_b_pos,
	output logic                    left_in_a_neg,
	output logic                    left_in_a_pos,
	output logic [1:0]              dac_current_sel,
	output logic signed [15:0]      left_fx_coef0,
	output logic signed [15:0]      left_fx_coef1
);
	logic        rst_sync1_reg;
	logic        rst_sync2_reg;
	logic        rst_n;
	cpcr_state_t state_reg;
	cpcr_state_t state_next;
	logic        p1_wr;
	logic        p0_wr;
	logic [15:0] coef0_q;
	logic [15:0] coef1_q;
	logic        hit_page_sel;
	logic        hit_coef0_high;
	logic        hit_coef0_low;
	logic        hit_coef1_high;
	logic        hit_coef1_low;
	logic        hit_bypass;
	logic        hit_dac_cur;
	logic        hit_rsvd;
	logic        wr_page_sel;
	logic        wr_coef0_high;
	logic        wr_coef0_low;
	logic        wr_coef1_high;
	logic        wr_coef1_low;
	logic        wr_bypass;
	logic        wr_dac_cur;
	logic [7:0]  rd_page0_data;
	logic [7:0]  rd_page1_data;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// page bit qualifies every strobe except index 0
	assign p0_wr = reg_wr && !state_reg.page;
	assign p1_wr = reg_wr && state_reg.page;

	// index decode shared by the write strobes and the read mux
	assign hit_page_sel   = (reg_idx == CPCR_IDX_PAGE_SEL);
	assign hit_coef0_high = (reg_idx == CPCR_IDX_COEF0_HIGH);
	assign hit_coef0_low  = (reg_idx == CPCR_IDX_COEF0_LOW);
	assign hit_coef1_high = (reg_idx == CPCR_IDX_COEF1_HIGH);
	assign hit_coef1_low  = (reg_idx == CPCR_IDX_COEF1_LOW);
	assign hit_bypass     = (reg_idx == CPCR_IDX_BYPASS);
	assign hit_dac_cur    = (reg_idx == CPCR_IDX_DAC_CUR);
	assign hit_rsvd       = (reg_idx >= CPCR_IDX_RSVD_FIRST);

	// index 0 ignores the page bit so the host can always switch back
	assign wr_page_sel   = reg_wr && hit_page_sel;
	assign wr_coef0_high = p1_wr && hit_coef0_high;
	assign wr_coef0_low  = p1_wr && hit_coef0_low;
	assign wr_coef1_high = p1_wr && hit_coef1_high;
	assign wr_coef1_low  = p1_wr && hit_coef1_low;
	assign wr_bypass     = p0_wr && hit_bypass;
	assign wr_dac_cur    = p0_wr && hit_dac_cur;

	// coefficient bytes latch independently; pairing discipline stays with host
	cpcr_coef_pair #(
		.RST_HIGH (CPCR_RST_COEF0_HIGH),
		.RST_LOW  (CPCR_RST_COEF0_LOW)
	) u_coef0 (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.wr_high (wr_coef0_high),
		.wr_low  (wr_coef0_low),
		.wdata   (reg_wdata),
		.coef    (coef0_q)
	);

	cpcr_coef_pair #(
		.RST_HIGH (CPCR_RST_COEF1_HIGH),
		.RST_LOW  (CPCR_RST_COEF1_LOW)
	) u_coef1 (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.wr_high (wr_coef1_high),
		.wr_low  (wr_coef1_low),
		.wdata   (reg_wdata),
		.coef    (coef1_q)
	);

	// page-1 read mux; indices past the coefficients read zero
	always_comb begin
		rd_page1_data = 8'h00;
		case (1'b1)
			hit_coef0_high: begin
				rd_page1_data = coef0_q[15:8];
			end
			hit_coef0_low: begin
				rd_page1_data = coef0_q[7:0];
			end
			hit_coef1_high: begin
				rd_page1_data = coef1_q[15:8];
			end
			hit_coef1_low: begin
				rd_page1_data = coef1_q[7:0];
			end
			default: begin
				rd_page1_data = 8'h00;
			end
		endcase
	end

	// page-0 read mux; dac bits 5..0 are not stored and read zero
	always_comb begin
		rd_page0_data = 8'h00;
		if (hit_bypass) begin
			rd_page0_data = state_reg.bypass;
		end else if (hit_dac_cur) begin
			rd_page0_data = {state_reg.dac_cur, 6'h00};
		end else if (hit_rsvd) begin
			rd_page0_data = 8'h00;
		end else begin
			rd_page0_data = 8'h00;
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.rvalid = reg_rd;
		if (wr_page_sel) begin
			state_next.page = reg_wdata[0];
		end
		if (wr_bypass) begin
			state_next.bypass = reg_wdata;
		end
		if (wr_dac_cur) begin
			// reserved code 10 is stored as written; the analog side treats it as default
			state_next.dac_cur = reg_wdata[CPCR_DAC_CUR_LSB +: 2];
		end
		state_next.rdata = 8'h00;
		if (reg_rd) begin
			if (hit_page_sel) begin
				state_next.rdata = {7'h00, state_reg.page};
			end else if (state_reg.page) begin
				state_next.rdata = rd_page1_data;
			end else begin
				state_next.rdata = rd_page0_data;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.page    <= CPCR_RST_PAGE_SEL[0];
			state_reg.bypass  <= CPCR_RST_BYPASS;
			state_reg.dac_cur <= CPCR_RST_DAC_CUR;
			state_reg.rdata   <= 8'h00;
			state_reg.rvalid  <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata       = state_reg.rdata;
	assign reg_rvalid      = state_reg.rvalid;
	assign active_page     = state_reg.page;
	assign right_in_b_neg  = state_reg.bypass[7];
	assign right_in_b_pos  = state_reg.bypass[6];
	assign right_in_a_neg  = state_reg.bypass[5];
	assign right_in_a_pos  = state_reg.bypass[4];
	assign left_in_b_neg   = state_reg.bypass[3];
	assign left_in_b_pos   = state_reg.bypass[2];
	assign left_in_a_neg   = state_reg.bypass[1];
	assign left_in_a_pos   = state_reg.bypass[0];
	assign dac_current_sel = state_reg.dac_cur;
	assign left_fx_coef0   = $signed(coef0_q);
	assign left_fx_coef1   = $signed(coef1_q);
endmodule : cpcr_regs

// ===== tb/codec_page_coeff_regs_tb_top.sv
`timescale 1ns/1ps
`define CK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module codec_page_coeff_regs_tb_top
	import cpcr_pkg::*;
;
	logic               ref_clk, rst_b, reg_wr, reg_rd, reg_rvalid, active_page;
	logic [6:0]         reg_idx;
	logic [7:0]         reg_wdata, reg_rdata, sw, q;
	logic [1:0]         dac_current_sel;
	logic signed [15:0] c0, c1;
	logic [7:0]         rv [4] = '{8'h6B, 8'hE3, 8'h96, 8'h66};
	int                 n_tests = 0, fail_count = 0, cyc = 0;
	cpcr_host i_cpcr_host (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_idx, .reg_wdata);
	cpcr_regs i_cpcr_regs (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_idx, .reg_wdata, .reg_rdata,
		.reg_rvalid, .active_page, .right_in_b_neg(sw[7]), .right_in_b_pos(sw[6]),
		.right_in_a_neg(sw[5]), .right_in_a_pos(sw[4]), .left_in_b_neg(sw[3]),
		.left_in_b_pos(sw[2]), .left_in_a_neg(sw[1]), .left_in_a_pos(sw[0]),
		.dac_current_sel, .left_fx_coef0(c0), .left_fx_coef1(c1));
	task final_report;
		if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// a hang costs one mismatch, far beyond the roughly one hundred cycles needed
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			final_report;
		end
	end
	initial begin
		rst_b = 1'b0;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk) rst_b = 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		`CK("c0", 16'sh6BE3, c0)
		`CK("c1", 16'sh9666, c1)
		`CK("sw", 8'h00, sw)
		`CK("dac", 2'h0, dac_current_sel)
		i_cpcr_host.wr(CPCR_IDX_COEF0_HIGH, 8'h55);
		`CK("p0 idx1", 16'sh6BE3, c0)
		i_cpcr_host.page(1'b1, q);
		`CK("page1", 8'h01, q)
		for (int k = 0; k < 4; k++) begin
			i_cpcr_host.rd(7'(k + 1), q);
			`CK("rst byte", rv[k], q)
		end
		i_cpcr_host.wr16(CPCR_IDX_COEF0_HIGH, 16'h8000);
		i_cpcr_host.wr16(CPCR_IDX_COEF1_HIGH, 16'h7FFF);
		`CK("c0 min", 16'sh8000, c0)
		`CK("c1 max", 16'sh7FFF, c1)
		i_cpcr_host.rd(CPCR_IDX_COEF1_LOW, q);
		`CK("rd c1lo", 8'hFF, q)
		i_cpcr_host.page(1'b0, q);
		`CK("page0", 8'h00, q)
		for (int k = 0; k < 8; k++) begin
			i_cpcr_host.wr(CPCR_IDX_BYPASS, 8'h01 << k);
			`CK("sw", 8'h01 << k, sw)
			i_cpcr_host.rd(CPCR_IDX_BYPASS, q);
			`CK("rd sw", 8'h01 << k, q)
		end
		for (int k = 0; k < 4; k++) begin
			i_cpcr_host.wr(CPCR_IDX_DAC_CUR, {2'(k), 6'h3F});
			`CK("dac", 2'(k), dac_current_sel)
			i_cpcr_host.rd(CPCR_IDX_DAC_CUR, q);
			`CK("rd dac", {2'(k), 6'h00}, q)
		end
		i_cpcr_host.wr(CPCR_IDX_RSVD_FIRST, 8'hFF);
		i_cpcr_host.wr(7'h7F, 8'hFF);
		i_cpcr_host.rd(CPCR_IDX_RSVD_FIRST, q);
		`CK("rsvd lo", 8'h00, q)
		i_cpcr_host.rd(7'h7F, q);
		`CK("rsvd hi", 8'h00, q)
		final_report;
	end
endmodule : codec_page_coeff_regs_tb_top
bind cpcr_regs cpcr_regs_chk i_cpcr_regs_chk (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_idx,
	.reg_wdata, .reg_rdata, .reg_rvalid, .active_page, .dac_current_sel, .left_fx_coef0,
	.left_fx_coef1);

// ===== tb/cpcr_host.sv
`timescale 1ns/1ps
module cpcr_host (
	input wire logic   ref_clk,
	input wire logic [7:0] reg_rdata,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [6:0] reg_idx,
	output logic [7:0] reg_wdata
);
	initial begin
		{reg_wr, reg_rd, reg_idx, reg_wdata} = 17'h00000;
	end
	// zeros forced into page bits 7..1 and dac bits 5..0
	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		@(negedge ref_clk);
		reg_idx = i;
		reg_wdata = (i == 7'h00) ? (d & 8'h01) : (i == 7'h6D) ? (d & 8'hC0) : d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
	endtask : wr
	task automatic rd(input logic [6:0] i, output logic [7:0] q);
		@(negedge ref_clk);
		reg_idx = i;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		q = reg_rdata;
		reg_rd = 1'b0;
	endtask : rd
	// high byte first, both bytes always; one switch bit at a time avoids shorts
	task automatic wr16(input logic [6:0] i, input logic [15:0] d);
		wr(i, d[15:8]);
		wr(i + 7'h01, d[7:0]);
	endtask : wr16
	task automatic page(input logic p, output logic [7:0] q);
		wr(7'h00, {7'h00, p});
		rd(7'h00, q);
	endtask : page
endmodule : cpcr_host

// ===== tb/cpcr_regs_chk.sv
`timescale 1ns/1ps
module cpcr_regs_chk
	import cpcr_pkg::*;
(
	input wire logic               ref_clk,
	input wire logic               rst_b,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [6:0]         reg_idx,
	input wire logic [7:0]         reg_wdata,
	input wire logic [7:0]         reg_rdata,
	input wire logic               reg_rvalid,
	input wire logic               active_page,
	input wire logic [1:0]         dac_current_sel,
	input wire logic signed [15:0] left_fx_coef0,
	input wire logic signed [15:0] left_fx_coef1
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
	rd_idle_a: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
		else $error("answer without read");
	page_set_a: assert property (reg_wr && reg_idx == 7'h00 |=> active_page == $past(reg_wdata[0]))
		else $error("page not taken");
	page_hold_a: assert property (!(reg_wr && reg_idx == 7'h00) |=> $stable(active_page))
		else $error("page moved");
	rsvd_zero_a: assert property (reg_rd && !active_page && reg_idx >= CPCR_IDX_RSVD_FIRST
		|=> reg_rdata == 8'h00) else $error("reserved read not zero");
	dac_field_a: assert property (reg_wr && !active_page && reg_idx == CPCR_IDX_DAC_CUR
		|=> dac_current_sel == $past(reg_wdata[7:6])) else $error("dac field wrong");
	coef_high_a: assert property (reg_wr && active_page && reg_idx == CPCR_IDX_COEF0_HIGH
		|=> left_fx_coef0[15:8] == $past(reg_wdata)) else $error("coef0 high wrong");
	coef_low_a: assert property (reg_wr && active_page && reg_idx == CPCR_IDX_COEF1_LOW
		|=> left_fx_coef1[7:0] == $past(reg_wdata)) else $error("coef1 low wrong");
endmodule : cpcr_regs_chk
